// File: logic/vpic_pkg.sv
// Constants, register map and helper functions of the vectored priority interrupt controller.
package vpic_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int          NUM_TRAP      = 8;
  localparam int          NUM_SRC       = 45;
  localparam int          NUM_VEC       = 62;
  localparam int          NUM_PRIO_REG  = 6;
  localparam int          SRC_VEC_FIRST = 8;
  localparam logic [7:0]  TRAP_IMPL     = 8'h1e;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL_TWO  = 12'h000;
  localparam logic [11:0] OFS_STATUS_WD = 12'h004;
  localparam logic [11:0] OFS_CORE_CTRL = 12'h008;
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h00c;
  localparam logic [11:0] OFS_IRQ_MASK  = 12'h010;
  localparam logic [11:0] OFS_PRIO_BASE = 12'h020;
  localparam logic [3:0]  PAGE_PRIMARY  = 4'h1;
  localparam logic [3:0]  PAGE_ALT      = 4'h2;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int          ALT_SEL_BIT   = 15;
  localparam int          NEST_DIS_BIT  = 0;
  localparam int          PRIO_LO_POS   = 5;
  localparam int          TRAP_PRIO_BIT = 3;
  localparam int          EV_IRQ_TAKEN  = 0;
  localparam int          EV_TRAP_TAKEN = 1;
  localparam int          EV_WR_IGNORED = 2;
  localparam int          NUM_EV        = 3;

  // ---------------------------------------------------------------------------
  // Reset values and vector fetch addresses
  // ---------------------------------------------------------------------------
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [23:0] RST_PC        = 24'h00_0000;
  localparam logic [23:0] TABLE_BASE    = 24'h00_0004;
  localparam logic [23:0] ALT_OFFSET    = 24'h00_0080;
  localparam logic [3:0]  TRAP_TOP_LVL  = 4'hf;

  // Fixed level of a trap: vector 0 is highest, vector 7 lowest.
  function automatic logic [3:0] trap_level(input logic [5:0] vec);
    trap_level = TRAP_TOP_LVL - vec[3:0];
  endfunction

  // Program memory location of a vector entry in the selected table.
  function automatic logic [23:0] vector_fetch(input logic alt, input logic [5:0] vec);
    vector_fetch = TABLE_BASE + (alt ? ALT_OFFSET : 24'h00_0000) + {17'h0_0000, vec, 1'b0};
  endfunction

endpackage

// File: logic/priority_resolver.sv
// Combinational selection of the winning trap or interrupt source.
`timescale 1ns/1ns
module priority_resolver
  import vpic_pkg::*;
(
  input  wire logic [NUM_SRC-1:0]   src_req,
  input  wire logic [NUM_SRC*3-1:0] src_prio,
  input  wire logic [NUM_TRAP-1:0]  trap_req,
  output logic                      win_valid,
  output logic [5:0]                win_vector,
  output logic [3:0]                win_level
);

  // Scanning from the highest vector down with >= lets the lowest vector win a tie.
  always_comb begin
    win_valid  = 1'b0;
    win_vector = 6'h00;
    win_level  = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (src_req[i] && (src_prio[i*3 +: 3] != 3'h0) &&
          ({1'b0, src_prio[i*3 +: 3]} >= win_level)) begin
        win_valid  = 1'b1;
        win_vector = 6'(SRC_VEC_FIRST + i);
        win_level  = {1'b0, src_prio[i*3 +: 3]};
      end
    end
    // Traps always outrank user sources; reserved trap slots never fire.
    for (int t = NUM_TRAP - 1; t >= 0; t--) begin
      if (trap_req[t] && TRAP_IMPL[t]) begin
        win_valid  = 1'b1;
        win_vector = 6'(t);
        win_level  = trap_level(6'(t));
      end
    end
  end

endmodule // priority_resolver

// File: logic/vpic_top.sv
// Vectored priority interrupt controller with an AHB-Lite register slave.
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns

// How it works
// - All sources merge into one core request.
// - Table of 62 vectors, eight traps first.
// - Each entry holds a 24-bit routine address.
// - Alternate select bit redirects every dispatch.
// - Alternate entry lies 0x80 above primary.
// - Traps 1-4 implemented, 0,5,6,7 reserved.
// - Sources use vectors 8 to 52.
// - Reset clears registers, program address zero.
// - Taken only above current CPU priority.
// - Sources 0-7, traps fixed at 8-15.
// - Priority zero source is never taken.
// - CPU priority is status bits plus trap bit.
// - Software level blocks equal or lower sources.
// - Low bits all ones mask users only.
// - Trap bit set by hardware, only cleared.
// - Nesting disabled makes low bits read-only.
// - Three-bit source priority, nibble top bit zero.
// - Ties go to lowest vector, no preemption.
module vpic_top
  import vpic_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [NUM_SRC-1:0]   src_req,
  input  wire logic [NUM_TRAP-1:0]  trap_req,
  input  wire logic                 core_ack,
  input  wire logic                 core_return,
  input  wire logic [3:0]           restore_level,
  output logic                      core_irq,
  output logic [5:0]                core_vector,
  output logic [3:0]                core_level,
  output logic [23:0]               core_fetch_addr,
  output logic [23:0]               core_isr_addr,
  output logic                      irq_out
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [31:0]               ctrl_two_q;
  logic [2:0]                cpu_prio_low_q;
  logic                      trap_prio_q;
  logic [NUM_EV-1:0]         ev_stat_q;
  logic [NUM_EV-1:0]         ev_mask_q;
  logic [31:0]               prio_q [NUM_PRIO_REG];
  logic [23:0]               vec_tab_q [2*NUM_VEC];
  logic                      wr_pend_q;
  logic                      rd_pend_q;
  logic [11:0]               addr_q;
  logic                      irq_q;
  logic [5:0]                vec_q;
  logic [3:0]                lvl_q;
  logic [23:0]               fetch_q;
  logic [23:0]               isr_q;
  logic                      int_q;
  logic [31:0]               hrdata_q;
  logic                      hready_q;
  logic                      win_valid;
  logic [5:0]                win_vector;
  logic [3:0]                win_level;
  logic [3:0]                cpu_prio;
  logic [NUM_SRC*3-1:0]      src_prio;
  logic                      alt_sel;
  logic                      nest_dis;
  logic                      take;
  logic                      wr_status_wd;
  logic                      wr_core_ctrl;
  logic [NUM_EV-1:0]         ev_set;

  assign alt_sel  = ctrl_two_q[ALT_SEL_BIT];
  assign nest_dis = ctrl_two_q[NEST_DIS_BIT];
  assign cpu_prio = {trap_prio_q, cpu_prio_low_q};

  // ---------------------------------------------------------------------------
  // AHB-Lite slave: writes take no wait state, reads take one.
  // ---------------------------------------------------------------------------
  logic accept;
  assign accept       = hsel && htrans[1] && hready;
  assign wr_status_wd = wr_pend_q && (addr_q == OFS_STATUS_WD);
  assign wr_core_ctrl = wr_pend_q && (addr_q == OFS_CORE_CTRL);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 12'h000;
      hready_q  <= 1'b1;
    end else begin
      wr_pend_q <= accept && hwrite;
      rd_pend_q <= accept && !hwrite;
      hready_q  <= !(accept && !hwrite);
      if (accept) begin
        addr_q <= {haddr[11:2], 2'b00};
      end
    end
  end

  // Table index for an address in either table page, or all ones when unmapped.
  function automatic logic [6:0] table_index(input logic [11:0] a);
    table_index = 7'h7f;
    if (a[7:2] < 6'(NUM_VEC)) begin
      if (a[11:8] == PAGE_PRIMARY) begin
        table_index = {1'b0, a[7:2]};
      end else if (a[11:8] == PAGE_ALT) begin
        table_index = 7'(NUM_VEC) + {1'b0, a[7:2]};
      end
    end
  endfunction

  function automatic logic [31:0] read_mux(input logic [11:0] a);
    logic [6:0] ti;
    ti       = table_index(a);
    read_mux = RST_WORD;
    if (a == OFS_CTRL_TWO) begin
      read_mux = ctrl_two_q;
    end else if (a == OFS_STATUS_WD) begin
      read_mux[PRIO_LO_POS +: 3] = cpu_prio_low_q;
    end else if (a == OFS_CORE_CTRL) begin
      read_mux[TRAP_PRIO_BIT] = trap_prio_q;
    end else if (a == OFS_IRQ_STAT) begin
      read_mux[NUM_EV-1:0] = ev_stat_q;
    end else if (a == OFS_IRQ_MASK) begin
      read_mux[NUM_EV-1:0] = ev_mask_q;
    end else if (a >= OFS_PRIO_BASE && a < OFS_PRIO_BASE + 12'(4 * NUM_PRIO_REG)) begin
      read_mux = prio_q[3'((a - OFS_PRIO_BASE) >> 2)];
    end else if (ti != 7'h7f) begin
      read_mux = {8'h00, vec_tab_q[ti]};
    end
  endfunction

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hrdata_q <= RST_WORD;
    end else if (rd_pend_q) begin
      hrdata_q <= read_mux(addr_q);
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_two_q <= RST_WORD;
      ev_mask_q  <= '0;
    end else if (wr_pend_q) begin
      if (addr_q == OFS_CTRL_TWO) begin
        ctrl_two_q <= RST_WORD;
        ctrl_two_q[ALT_SEL_BIT]  <= hwdata[ALT_SEL_BIT];
        ctrl_two_q[NEST_DIS_BIT] <= hwdata[NEST_DIS_BIT];
      end
      if (addr_q == OFS_IRQ_MASK) begin
        ev_mask_q <= hwdata[NUM_EV-1:0];
      end
    end
  end

  // Bit 3 of each nibble is never stored, so it always reads zero.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int r = 0; r < NUM_PRIO_REG; r++) begin
        prio_q[r] <= RST_WORD;
      end
    end else if (wr_pend_q && addr_q >= OFS_PRIO_BASE &&
                 addr_q < OFS_PRIO_BASE + 12'(4 * NUM_PRIO_REG)) begin
      prio_q[3'((addr_q - OFS_PRIO_BASE) >> 2)] <= hwdata & 32'h7777_7777;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int v = 0; v < 2 * NUM_VEC; v++) begin
        vec_tab_q[v] <= RST_PC;
      end
    end else if (wr_pend_q && table_index(addr_q) != 7'h7f) begin
      vec_tab_q[table_index(addr_q)] <= hwdata[23:0];
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      src_prio[i*3 +: 3] = prio_q[i / 8][(i % 8) * 4 +: 3];
    end
  end

  // ---------------------------------------------------------------------------
  // CPU priority: hardware dispatch and return update it and win over software.
  // ---------------------------------------------------------------------------
  assign take = irq_q && core_ack;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_prio_low_q <= 3'h0;
      trap_prio_q    <= 1'b0;
    end else if (take) begin
      cpu_prio_low_q <= lvl_q[2:0];
      trap_prio_q    <= trap_prio_q | lvl_q[3];
    end else if (core_return) begin
      cpu_prio_low_q <= restore_level[2:0];
      trap_prio_q    <= restore_level[3];
    end else begin
      if (wr_status_wd && !nest_dis) begin
        cpu_prio_low_q <= hwdata[PRIO_LO_POS +: 3];
      end
      if (wr_core_ctrl) begin
        trap_prio_q <= trap_prio_q & hwdata[TRAP_PRIO_BIT];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Source selection and dispatch to the core
  // ---------------------------------------------------------------------------
  priority_resolver u_resolver (
    .src_req    (src_req),
    .src_prio   (src_prio),
    .trap_req   (trap_req),
    .win_valid  (win_valid),
    .win_vector (win_vector),
    .win_level  (win_level)
  );

  // The offered vector is frozen until acknowledged, so a newer source waits.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_q   <= 1'b0;
      vec_q   <= 6'h00;
      lvl_q   <= 4'h0;
      fetch_q <= RST_PC;
      isr_q   <= RST_PC;
    end else if (take) begin
      irq_q <= 1'b0;
    end else if (!irq_q && !core_return && win_valid && win_level > cpu_prio) begin
      irq_q   <= 1'b1;
      vec_q   <= win_vector;
      lvl_q   <= win_level;
      fetch_q <= vector_fetch(alt_sel, win_vector);
      isr_q   <= vec_tab_q[alt_sel ? 7'(NUM_VEC) + {1'b0, win_vector}
                                   : {1'b0, win_vector}];
    end
  end

  assign core_irq        = irq_q;
  assign core_vector     = vec_q;
  assign core_level      = lvl_q;
  assign core_fetch_addr = fetch_q;
  assign core_isr_addr   = isr_q;

  // ---------------------------------------------------------------------------
  // Event status, mask and interrupt output
  // ---------------------------------------------------------------------------
  always_comb begin
    ev_set                = '0;
    ev_set[EV_IRQ_TAKEN]  = take && !lvl_q[3];
    ev_set[EV_TRAP_TAKEN] = take && lvl_q[3];
    ev_set[EV_WR_IGNORED] = wr_status_wd && nest_dis;
  end

  logic [NUM_EV-1:0] ev_stat_d;
  always_comb begin
    ev_stat_d = ev_stat_q;
    if (wr_pend_q && addr_q == OFS_IRQ_STAT) begin
      ev_stat_d = ev_stat_q & ~hwdata[NUM_EV-1:0];
    end
    ev_stat_d = ev_stat_d | ev_set;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ev_stat_q <= '0;
      int_q     <= 1'b0;
    end else begin
      ev_stat_q <= ev_stat_d;
      int_q     <= |(ev_stat_d & ev_mask_q);
    end
  end

  assign irq_out = int_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_raise_above_cpu: assert property ($rose(irq_q) |-> $past(win_level) > $past(cpu_prio))
    else $error("request raised without beating CPU priority");
  a_hold_until_ack: assert property (irq_q && !core_ack |=> irq_q && $stable(vec_q) &&
                                     $stable(lvl_q) && $stable(isr_q))
    else $error("offered vector changed before acknowledge");
  a_fetch_table_sel: assert property ($rose(irq_q) |-> fetch_q ==
                                      24'h00_0004 + ($past(alt_sel) ? 24'h00_0080 : 24'h0) +
                                      {17'h0, vec_q, 1'b0})
    else $error("vector fetch address wrong for table");
  a_prio_zero_off: assert property (irq_q |-> lvl_q != 4'h0)
    else $error("priority zero source was offered");
  a_trap_fixed_lvl: assert property (irq_q && vec_q < 6'd8 |-> lvl_q == 4'hf - vec_q[3:0] &&
                                     vec_q >= 6'd1 && vec_q <= 6'd4)
    else $error("trap offered at wrong level or reserved slot");
  a_user_lvl_range: assert property (irq_q && vec_q >= 6'd8 |-> lvl_q <= 4'd7 &&
                                     vec_q <= 6'd52)
    else $error("user source outside vectors or levels");
  a_trap_bit_no_set: assert property (wr_core_ctrl && !trap_prio_q && !take && !core_return
                                      |=> !trap_prio_q)
    else $error("software set the trap priority bit");
  a_nest_read_only: assert property (wr_status_wd && nest_dis && !take && !core_return
                                     |=> $stable(cpu_prio_low_q))
    else $error("low priority bits written while nesting disabled");
  a_ack_raises_cpu: assert property (take |=> cpu_prio[2:0] == $past(lvl_q[2:0]) &&
                                     (!$past(lvl_q[3]) || trap_prio_q))
    else $error("CPU priority not raised on acknowledge");
  a_read_one_wait: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");
  a_int_follows: assert property (##1 irq_out == |($past(ev_stat_d) & $past(ev_mask_q)))
    else $error("interrupt output disagrees with masked status");

  c_trap_taken:  cover property (take && lvl_q[3]);
  c_alt_dispatch: cover property ($rose(irq_q) && alt_sel);
  c_nested_irq:  cover property ($rose(irq_q) && cpu_prio != 4'h0 && !lvl_q[3]);
  c_ignored_wr:  cover property (ev_set[EV_WR_IGNORED]);

endmodule // vpic_top

// File: sim/core_model.sv
// CPU core model that takes offered vectors and returns from service on command.
`timescale 1ns/1ns
module core_model (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        core_irq,
  input  wire logic [5:0]  core_vector,
  input  wire logic [3:0]  core_level,
  input  wire logic [23:0] core_fetch_addr,
  input  wire logic [23:0] core_isr_addr,
  input  wire logic [3:0]  ack_wait,
  input  wire logic        ret_go,
  input  wire logic [3:0]  ret_lvl,
  output logic             core_ack,
  output logic             core_return,
  output logic [3:0]       restore_level,
  output int               taken,
  output int               unstable,
  output logic [57:0]      got
);
  logic [3:0]  wait_q;
  logic        seen_q;
  logic [57:0] held_q;
  wire  logic [57:0] offer = {core_vector, core_level, core_fetch_addr, core_isr_addr};

  // The offer must not move between the rise of the request and the acknowledge.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      core_ack <= 1'b0;
      wait_q   <= 4'h0;
      seen_q   <= 1'b0;
      held_q   <= '0;
      taken    <= 0;
      unstable <= 0;
      got      <= '0;
    end else begin
      core_ack <= 1'b0;
      seen_q   <= core_irq && !core_ack;
      held_q   <= offer;
      if (seen_q && core_irq && offer !== held_q) begin
        unstable <= unstable + 1;
      end
      if (core_irq && core_ack) begin
        taken <= taken + 1;
        got   <= offer;
      end else if (core_irq && wait_q >= ack_wait) begin
        core_ack <= 1'b1;
        wait_q   <= 4'h0;
      end else if (core_irq) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      core_return   <= 1'b0;
      restore_level <= 4'h0;
    end else begin
      core_return   <= ret_go;
      restore_level <= ret_lvl;
    end
  end
endmodule // core_model

// File: sim/test_vectored_priority_interrupt_controller.sv
// Self-checking bench of the vectored priority interrupt controller.
`timescale 1ns/1ns
module test_vectored_priority_interrupt_controller
  import vpic_pkg::*;
;
  logic                core_clk = 1'b0;
  logic                resetn = 1'b0;
  logic                hsel = 1'b0;
  logic                hwrite = 1'b0;
  logic                ret_go = 1'b0;
  logic [31:0]         haddr = 32'h0000_0000;
  logic [31:0]         hwdata = 32'h0000_0000;
  logic [1:0]          htrans = 2'h0;
  logic [2:0]          hsize = 3'h2;
  logic [NUM_SRC-1:0]  src_req = '0;
  logic [NUM_TRAP-1:0] trap_req = '0;
  logic [3:0]          ack_wait = 4'h0;
  logic [3:0]          ret_lvl = 4'h0;
  logic [31:0]         hrdata;
  logic [31:0]         rd;
  logic                hreadyout, hresp, core_irq, core_ack, core_return, irq_out;
  logic [5:0]          core_vector;
  logic [3:0]          core_level, restore_level;
  logic [23:0]         core_fetch_addr, core_isr_addr;
  logic [57:0]         got;
  int                  taken, unstable, exp_taken = 0;
  int                  failures = 0, check_count = 0, cycles = 0;

  vpic_top vpic_top_inst (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req),
    .trap_req(trap_req), .core_ack(core_ack), .core_return(core_return),
    .restore_level(restore_level), .core_irq(core_irq), .core_vector(core_vector),
    .core_level(core_level), .core_fetch_addr(core_fetch_addr),
    .core_isr_addr(core_isr_addr), .irq_out(irq_out));

  core_model core_model_inst (.core_clk(core_clk), .resetn(resetn), .core_irq(core_irq),
    .core_vector(core_vector), .core_level(core_level), .core_fetch_addr(core_fetch_addr),
    .core_isr_addr(core_isr_addr), .ack_wait(ack_wait), .ret_go(ret_go), .ret_lvl(ret_lvl),
    .core_ack(core_ack), .core_return(core_return), .restore_level(restore_level),
    .taken(taken), .unstable(unstable), .got(got));

  always #5 core_clk = ~core_clk;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic ahb(input logic wr_en, input logic [31:0] addr, input logic [31:0] wd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'b10;
    hwrite <= wr_en;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
    ahb(1'b1, addr, wd);
  endtask

  task automatic rdchk(input string what, input logic [31:0] addr, input logic [31:0] exp);
    ahb(1'b0, addr, 32'h0000_0000);
    check(what, rd, exp);
  endtask

  function automatic logic [31:0] r(input logic [11:0] ofs);
    r = {20'h0_0000, ofs};
  endfunction

  function automatic logic [31:0] tab(input logic alt, input logic [5:0] v);
    tab = {20'h0_0000, alt ? PAGE_ALT : PAGE_PRIMARY, v, 2'b00};
  endfunction

  function automatic logic [31:0] pw(input logic [2:0] w);
    pw = r(OFS_PRIO_BASE) + {27'h000_0000, w, 2'b00};
  endfunction

  task automatic expect_take(input logic [5:0] v, input logic [3:0] l, input logic [23:0] f,
                             input logic [23:0] service_routine);
    exp_taken++;
    while (taken < exp_taken) @(posedge core_clk);
    check("vector", 32'(got[57:52]), 32'(v));
    check("level", 32'(got[51:48]), 32'(l));
    check("fetch address", 32'(got[47:24]), 32'(f));
    check("routine address", 32'(got[23:0]), 32'(service_routine));
  endtask

  task automatic no_take;
    repeat (20) @(posedge core_clk);
    check("offers taken", 32'(taken), 32'(exp_taken));
  endtask

  task automatic give_back(input logic [3:0] lvl);
    @(posedge core_clk);
    ret_go  <= 1'b1;
    ret_lvl <= lvl;
    @(posedge core_clk);
    ret_go <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    check("core_irq", 32'(core_irq), 32'h0000_0000);
    check("fetch after reset", 32'(core_fetch_addr), 32'h0000_0000);
    check("hresp", 32'(hresp), 32'h0000_0000);
    rdchk("control two", r(OFS_CTRL_TWO), 32'h0000_0000);
    rdchk("status word", r(OFS_STATUS_WD), 32'h0000_0000);
    rdchk("core control", r(OFS_CORE_CTRL), 32'h0000_0000);
    rdchk("priority word", pw(3'h0), 32'h0000_0000);
    wr(32'h0000_0014, 32'hFFFF_FFFF);
    rdchk("unmapped", 32'h0000_0014, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_basic;
    wr(tab(1'b0, 6'h08), 32'hFFAB_CDEF);
    rdchk("table entry", tab(1'b0, 6'h08), 32'h00AB_CDEF);
    wr(pw(3'h0), 32'h0000_0003);
    src_req[0] <= 1'b1;
    expect_take(6'h08, 4'h3, 24'h00_0014, 24'hAB_CDEF);
    src_req[0] <= 1'b0;
    rdchk("status word", r(OFS_STATUS_WD), 32'h0000_0060);
    rdchk("event status", r(OFS_IRQ_STAT), 32'h0000_0001);
    check("irq_out masked", 32'(irq_out), 32'h0000_0000);
    wr(r(OFS_IRQ_MASK), 32'h0000_0001);
    rdchk("event mask", r(OFS_IRQ_MASK), 32'h0000_0001);
    check("irq_out set", 32'(irq_out), 32'h0000_0001);
    wr(r(OFS_IRQ_STAT), 32'h0000_0001);
    rdchk("event status", r(OFS_IRQ_STAT), 32'h0000_0000);
    check("irq_out clear", 32'(irq_out), 32'h0000_0000);
    give_back(4'h0);
    $display("test basic done");
  endtask

  task automatic t_levels;
    ack_wait <= 4'h6;
    wr(r(OFS_STATUS_WD), 32'h0000_0060);
    wr(pw(3'h0), 32'h0000_0030);
    src_req[1] <= 1'b1;
    no_take;
    wr(pw(3'h0), 32'h0000_0040);
    expect_take(6'h09, 4'h4, 24'h00_0016, 24'h00_0000);
    src_req[1] <= 1'b0;
    give_back(4'h3);
    rdchk("returned level", r(OFS_STATUS_WD), 32'h0000_0060);
    wr(r(OFS_STATUS_WD), 32'h0000_0000);
    wr(pw(3'h0), 32'h0000_0000);
    src_req[2] <= 1'b1;
    no_take;
    src_req[2] <= 1'b0;
    $display("test levels done");
  endtask

  task automatic t_trap;
    ack_wait <= 4'h1;
    wr(r(OFS_CTRL_TWO), 32'h0000_8000);
    wr(tab(1'b1, 6'h04), 32'h0012_3456);
    wr(tab(1'b1, 6'h08), 32'h0000_5A5A);
    wr(r(OFS_STATUS_WD), 32'h0000_00E0);
    wr(pw(3'h0), 32'h0000_0007);
    src_req[0] <= 1'b1;
    trap_req <= 8'h01;
    no_take;
    trap_req <= 8'h10;
    expect_take(6'h04, 4'hB, 24'h00_008C, 24'h12_3456);
    trap_req <= 8'h00;
    rdchk("trap bit", r(OFS_CORE_CTRL), 32'h0000_0008);
    wr(r(OFS_CORE_CTRL), 32'h0000_0000);
    expect_take(6'h08, 4'h7, 24'h00_0094, 24'h00_5A5A);
    src_req[0] <= 1'b0;
    wr(r(OFS_CORE_CTRL), 32'h0000_0008);
    rdchk("trap bit", r(OFS_CORE_CTRL), 32'h0000_0000);
    wr(r(OFS_CTRL_TWO), 32'h0000_0000);
    give_back(4'h0);
    $display("test trap done");
  endtask

  task automatic t_tie;
    ack_wait <= 4'h3;
    wr(pw(3'h1), 32'hFFFF_FFFF);
    rdchk("priority word", pw(3'h1), 32'h7777_7777);
    wr(pw(3'h1), 32'h0000_0000);
    wr(pw(3'h0), 32'h0000_0550);
    src_req[2:1] <= 2'b11;
    expect_take(6'h09, 4'h5, 24'h00_0016, 24'h00_0000);
    src_req[1] <= 1'b0;
    no_take;
    give_back(4'h0);
    expect_take(6'h0A, 4'h5, 24'h00_0018, 24'h00_0000);
    src_req[2] <= 1'b0;
    give_back(4'h0);
    $display("test tie done");
  endtask

  task automatic t_nest;
    wr(r(OFS_CTRL_TWO), 32'h0000_0001);
    wr(r(OFS_STATUS_WD), 32'h0000_0060);
    rdchk("locked level", r(OFS_STATUS_WD), 32'h0000_0000);
    ahb(1'b0, r(OFS_IRQ_STAT), 32'h0000_0000);
    check("event flags", rd, 32'h0000_0007);
    wr(r(OFS_IRQ_STAT), 32'h0000_0007);
    wr(r(OFS_CTRL_TWO), 32'h0000_0000);
    wr(r(OFS_STATUS_WD), 32'h0000_0020);
    rdchk("open level", r(OFS_STATUS_WD), 32'h0000_0020);
    check("offer stability", 32'(unstable), 32'h0000_0000);
    $display("test nesting done");
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_basic();
    t_levels();
    t_trap();
    t_tie();
    t_nest();
    report_and_stop();
  end
endmodule // test_vectored_priority_interrupt_controller
